/* File: inc/timer_params.svh */
// Offsets, field positions, reset values and clock-select codes of the dual timer.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register word addresses
`define ADDR_CLK_SEL      4'h0
`define ADDR_COMPARE_ONE  4'h1
`define ADDR_COMPARE_TWO  4'h2
`define ADDR_OUT_CTRL     4'h3
`define ADDR_OSC_MODE     4'h4
`define ADDR_COUNT_ONE    4'h5
`define ADDR_COUNT_TWO    4'h6
`define ADDR_IRQ_STATUS   4'h7
`define ADDR_IRQ_MASK     4'h8
`define ADDR_RUN_CTRL     4'h9

// Clock-select field positions: channel one low nibble, channel two high nibble
`define SEL_ONE_LSB       0
`define SEL_TWO_LSB       4

// Output control field positions within one channel nibble
`define OCR_CH_STRIDE     4
`define OCR_WAVE_EN       0
`define OCR_INVERT_EN     1
`define OCR_FF_CLEAR      2
`define OCR_FF_SET        3

// Clock-select codes
`define SEL_EXT_FALL      4'h0
`define SEL_EXT_RISE      4'h1
`define SEL_INT_FIRST     4'h6
`define SEL_INT_LAST      4'hE
`define SEL_INT_TOP       4'hF
`define SEL_INT_BASE      4'h5
`define SEL_TOP_SHIFT     4'hB

// Prescaler width covers the largest divisor of 2^12
`define PRESC_W           12

// Reset values
`define RST_BYTE          8'h00
`define RST_SEL           4'h0
`define RST_OSC_MODE      1'b0
`define RST_BIT           1'b0
`define RST_PRESC         12'h000
`endif

/* File: inc/timer_pkg.sv */
// Types shared by the dual 8-bit timer.
// Assumes the constants header is on the include path.
`default_nettype none
package timer_pkg;
  `include "timer_params.svh"

  // Register port request from the bus master
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // State of one timer channel
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] compare;
    logic [3:0] sel;
    logic       ff;
    logic       invert_en;
    logic       wave_en;
    logic       run;
    logic [2:0] sync;
  } chan_t;

  // Whole block state
  typedef struct packed {
    chan_t [1:0]           ch;
    logic [`PRESC_W-1:0]   presc;
    logic                  osc_mode;
    logic [1:0]            status;
    logic [1:0]            mask;
    logic [7:0]            rdata;
    logic                  irq;
  } state_t;
endpackage
`default_nettype wire

/* File: rtl/dual_8bit_event_timer.sv */
// Two independent 8-bit timer/event counters with compare clear and square-wave output.
// Assumes clk is the main oscillator, event pins are asynchronous, registers on a plain port.
//
// Summary of operation
// - Codes 0000 and 0001 count edges of the channel's external event input; other unlisted codes do not count.
// - Codes 0110 to 1110 divide the oscillator by 2^1 to 2^9, 1111 by 2^11, doubled when the mode bit is 0.
// - Each channel compares against an 8-bit value N, giving a period of N+1 count clocks.
// - Event pin one feeds counter one and event pin two feeds counter two.
// - Each valid event edge increments the counter, with rising or falling chosen by the select code.
// - When a counter equals its compare value it clears to zero and raises its interrupt request.
// - With the channel output and inversion both enabled the output flip-flop inverts at every compare match.
// - Square-wave half periods run from one to 2^8 count clocks in steps of one count clock.
// - Counter one takes its clock select from bits 0 to 3 and counter two from bits 4 to 7.
// - After a compare match counting continues and a request is raised every period.
// - Writing 10 sets the output flip-flop, 01 clears it, 00 leaves it, 11 is ignored, both read as 0.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module dual_8bit_event_timer
  import timer_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire bus_req_t bus_req,
  input  wire logic     event_in_one,
  input  wire logic     event_in_two,
  output logic [7:0]    rdata,
  output logic          irq,
  output logic          wave_out_one,
  output logic          wave_oe_one,
  output logic          wave_out_two,
  output logic          wave_oe_two
);

  state_t cur_reg;
  state_t cur_next;

  // Prescaler exponent for an internal select code, or zero when the code is not internal
  function automatic logic [3:0] div_shift(input logic [3:0] sel, input logic mode);
    logic [3:0] k;
    k = 4'h0;
    if (sel >= `SEL_INT_FIRST && sel <= `SEL_INT_LAST) begin
      k = sel - `SEL_INT_BASE;
    end else if (sel == `SEL_INT_TOP) begin
      k = `SEL_TOP_SHIFT;
    end
    if (k != 4'h0 && !mode) begin
      k = k + 4'h1;
    end
    return k;
  endfunction

  // One-cycle tick every 2^k oscillator cycles from the free-running prescaler
  function automatic logic presc_tick(input logic [3:0] k,
                                      input logic [`PRESC_W-1:0] presc);
    logic [`PRESC_W-1:0] m;
    m = (`PRESC_W'(1) << k) - `PRESC_W'(1);
    return (k != 4'h0) && ((presc & m) == m);
  endfunction

  // Count clock of one channel: prescaler tick or a valid edge of its event pin
  function automatic logic count_tick(input chan_t c, input logic mode,
                                      input logic [`PRESC_W-1:0] presc);
    logic rise;
    logic fall;
    rise = c.sync[1] & ~c.sync[2];
    fall = ~c.sync[1] & c.sync[2];
    case (c.sel)
      `SEL_EXT_FALL: count_tick = fall;
      `SEL_EXT_RISE: count_tick = rise;
      default:       count_tick = presc_tick(div_shift(c.sel, mode), presc);
    endcase
  endfunction

  // Readback of a register word
  function automatic logic [7:0] read_word(input state_t s, input logic [3:0] a);
    case (a)
      `ADDR_CLK_SEL:     read_word = {s.ch[1].sel, s.ch[0].sel};
      `ADDR_COMPARE_ONE: read_word = s.ch[0].compare;
      `ADDR_COMPARE_TWO: read_word = s.ch[1].compare;
      // Set and clear bits always read back as zero
      `ADDR_OUT_CTRL:    read_word = {2'b00, s.ch[1].invert_en, s.ch[1].wave_en,
                                      2'b00, s.ch[0].invert_en, s.ch[0].wave_en};
      `ADDR_OSC_MODE:    read_word = {7'h00, s.osc_mode};
      `ADDR_COUNT_ONE:   read_word = s.ch[0].count;
      `ADDR_COUNT_TWO:   read_word = s.ch[1].count;
      `ADDR_IRQ_STATUS:  read_word = {6'h00, s.status};
      `ADDR_IRQ_MASK:    read_word = {6'h00, s.mask};
      `ADDR_RUN_CTRL:    read_word = {6'h00, s.ch[1].run, s.ch[0].run};
      default:           read_word = 8'h00;
    endcase
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [1:0] hit;
    logic [1:0] w1c;
    logic [3:0] nib;
    logic       ev;
    cur_next = cur_reg;
    hit = 2'b00;
    w1c = 2'b00;
    nib = 4'h0;
    ev = 1'b0;

    // Free-running divider of the main oscillator
    cur_next.presc = cur_reg.presc + `PRESC_W'(1);

    for (int i = 0; i < 2; i++) begin
      // Two-stage synchroniser plus one history stage for edge detection
      ev = (i == 0) ? event_in_one : event_in_two;
      cur_next.ch[i].sync = {cur_reg.ch[i].sync[1:0], ev};

      // Count, clear on match and keep running
      if (cur_reg.ch[i].run &&
          count_tick(cur_reg.ch[i], cur_reg.osc_mode, cur_reg.presc)) begin
        if (cur_reg.ch[i].count == cur_reg.ch[i].compare) begin
          cur_next.ch[i].count = 8'h00;
          hit[i] = 1'b1;
          if (cur_reg.ch[i].wave_en && cur_reg.ch[i].invert_en) begin
            cur_next.ch[i].ff = ~cur_reg.ch[i].ff;
          end
        end else begin
          cur_next.ch[i].count = cur_reg.ch[i].count + 8'h01;
        end
      end
    end

    // Register writes; a direct set or clear of the flip-flop wins over a toggle
    if (bus_req.wr) begin
      case (bus_req.addr)
        `ADDR_CLK_SEL: begin
          cur_next.ch[0].sel = bus_req.wdata[`SEL_ONE_LSB +: 4];
          cur_next.ch[1].sel = bus_req.wdata[`SEL_TWO_LSB +: 4];
        end
        `ADDR_COMPARE_ONE: cur_next.ch[0].compare = bus_req.wdata;
        `ADDR_COMPARE_TWO: cur_next.ch[1].compare = bus_req.wdata;
        `ADDR_OUT_CTRL: begin
          for (int i = 0; i < 2; i++) begin
            nib = bus_req.wdata[i*`OCR_CH_STRIDE +: 4];
            cur_next.ch[i].wave_en = nib[`OCR_WAVE_EN];
            cur_next.ch[i].invert_en = nib[`OCR_INVERT_EN];
            if (nib[`OCR_FF_SET] && !nib[`OCR_FF_CLEAR]) begin
              cur_next.ch[i].ff = 1'b1;
            end else if (!nib[`OCR_FF_SET] && nib[`OCR_FF_CLEAR]) begin
              cur_next.ch[i].ff = 1'b0;
            end
          end
        end
        `ADDR_OSC_MODE:   cur_next.osc_mode = bus_req.wdata[0];
        `ADDR_IRQ_STATUS: w1c = bus_req.wdata[1:0];
        `ADDR_IRQ_MASK:   cur_next.mask = bus_req.wdata[1:0];
        `ADDR_RUN_CTRL: begin
          cur_next.ch[0].run = bus_req.wdata[0];
          cur_next.ch[1].run = bus_req.wdata[1];
        end
        default: ;
      endcase
    end

    // Sticky match flags: a new match wins over a clear in the same cycle
    cur_next.status = (cur_reg.status & ~w1c) | hit;
    cur_next.irq = |(cur_next.status & cur_next.mask);

    // Read data stands only in the cycle after the read strobe
    cur_next.rdata = bus_req.rd ? read_word(cur_reg, bus_req.addr) : 8'h00;
  end

  // State register with asynchronous reset to constants
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        cur_reg.ch[i].count <= `RST_BYTE;
        cur_reg.ch[i].compare <= `RST_BYTE;
        cur_reg.ch[i].sel <= `RST_SEL;
        cur_reg.ch[i].ff <= `RST_BIT;
        cur_reg.ch[i].invert_en <= `RST_BIT;
        cur_reg.ch[i].wave_en <= `RST_BIT;
        cur_reg.ch[i].run <= `RST_BIT;
        cur_reg.ch[i].sync <= 3'b000;
      end
      cur_reg.presc <= `RST_PRESC;
      cur_reg.osc_mode <= `RST_OSC_MODE;
      cur_reg.status <= 2'b00;
      cur_reg.mask <= 2'b00;
      cur_reg.rdata <= `RST_BYTE;
      cur_reg.irq <= `RST_BIT;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs come straight from state flip-flops
  assign rdata = cur_reg.rdata;
  assign irq = cur_reg.irq;
  assign wave_out_one = cur_reg.ch[0].ff;
  assign wave_oe_one = cur_reg.ch[0].wave_en;
  assign wave_out_two = cur_reg.ch[1].ff;
  assign wave_oe_two = cur_reg.ch[1].wave_en;

endmodule
`default_nettype wire

/* File: verification/dual_8bit_event_timer_assertions.sv */
// Port-level checker for the dual 8-bit timer, attached by bind.
// Assumes timer_pkg is compiled first; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module dual_8bit_event_timer_assertions
  import timer_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire bus_req_t   bus_req,
  input wire logic       event_in_one,
  input wire logic       event_in_two,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       wave_out_one,
  input wire logic       wave_oe_one,
  input wire logic       wave_out_two,
  input wire logic       wave_oe_two
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write strobe aimed at the output control register
  logic w3;
  assign w3 = bus_req.wr && bus_req.addr == 4'h3;
  // Mask write that clears both enables
  sequence s_mask_off;
    bus_req.wr && bus_req.addr == 4'h8 && bus_req.wdata[1:0] == 2'b00;
  endsequence
  property p_reset_quiet;
    $rose(rst_n) |-> !irq && !wave_out_one && !wave_out_two && rdata == 8'h00;
  endproperty
  property p_oe_one;
    w3 |=> wave_oe_one == $past(bus_req.wdata[0]);
  endproperty
  property p_oe_two;
    w3 |=> wave_oe_two == $past(bus_req.wdata[4]);
  endproperty
  property p_set_one;
    w3 && bus_req.wdata[3:2] == 2'b10 |=> wave_out_one;
  endproperty
  property p_clear_one;
    w3 && bus_req.wdata[3:2] == 2'b01 |=> !wave_out_one;
  endproperty
  property p_set_two;
    w3 && bus_req.wdata[7:6] == 2'b10 |=> wave_out_two;
  endproperty
  property p_readback;
    bus_req.rd && bus_req.addr == 4'h3 |=> rdata[3:2] == 2'b00 && rdata[7:6] == 2'b00;
  endproperty
  property p_mask_off;
    s_mask_off |=> ##1 !irq;
  endproperty
  property p_toggle_cause;
    $changed(wave_out_one) |-> $past(wave_oe_one) || $past(w3);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset exit");
  a_oe_one: assert property (p_oe_one) else $error("channel one enable wrong");
  a_oe_two: assert property (p_oe_two) else $error("channel two enable wrong");
  a_set_one: assert property (p_set_one) else $error("channel one set failed");
  a_clear_one: assert property (p_clear_one) else $error("channel one clear failed");
  a_set_two: assert property (p_set_two) else $error("channel two set failed");
  a_readback: assert property (p_readback) else $error("set or clear bit read as 1");
  a_mask_off: assert property (p_mask_off) else $error("irq high with mask off");
  a_toggle_cause: assert property (p_toggle_cause) else $error("output moved while off");
endmodule
bind dual_8bit_event_timer dual_8bit_event_timer_assertions i_chk (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .event_in_one(event_in_one),
  .event_in_two(event_in_two), .rdata(rdata), .irq(irq), .wave_out_one(wave_out_one),
  .wave_oe_one(wave_oe_one), .wave_out_two(wave_out_two), .wave_oe_two(wave_oe_two));
`default_nettype wire

/* File: verification/dual_8bit_event_timer_test.sv */
// Self-checking bench for the dual 8-bit timer, driven through its register port.
// Assumes timer_pkg and the design are compiled first.
`timescale 1ns/1ns
`default_nettype none
module dual_8bit_event_timer_test
  import timer_pkg::*;
;
  logic clk, rst_n, event_in_one, event_in_two, irq;
  logic wave_out_one, wave_oe_one, wave_out_two, wave_oe_two;
  logic [7:0] rdata;
  bus_req_t bus_req;
  int fail_count = 0;
  int n_compared = 0;
  dual_8bit_event_timer i_dual_8bit_event_timer (
    .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .event_in_one(event_in_one),
    .event_in_two(event_in_two), .rdata(rdata), .irq(irq), .wave_out_one(wave_out_one),
    .wave_oe_one(wave_oe_one), .wave_out_two(wave_out_two), .wave_oe_two(wave_oe_two));
  // Free running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle write, then one idle cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  // Read data is looked at mid-way through the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus_req <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask
  task automatic pulse(input bit ch, input int n);
    repeat (n) begin
      if (ch) event_in_two <= 1'b1;
      else event_in_one <= 1'b1;
      repeat (4) @(posedge clk);
      if (ch) event_in_two <= 1'b0;
      else event_in_one <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // Sync to one output edge, then count clocks to the next one
  task automatic meas(input bit ch, input int e);
    logic w;
    int n;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      w = ch ? wave_out_two : wave_out_one;
      n = 1;
      while ((ch ? wave_out_two : wave_out_one) === w && n < 9000) begin
        @(negedge clk);
        n++;
      end
    end
    chk(n[15:0], e[15:0]);
  endtask
  // Hang guard well beyond the expected run length
  initial begin
    #640000;
    fail_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    event_in_one = 1'b0;
    event_in_two = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 11; a++) rd(a[3:0], 8'h00);
    // Event counting: channel one falling, channel two rising
    wr(4'h1, 8'hFF);
    wr(4'h2, 8'hFF);
    wr(4'h0, 8'h10);
    wr(4'h9, 8'h03);
    // A rising edge alone must not move a falling-edge counter
    event_in_one <= 1'b1;
    repeat (6) @(posedge clk);
    rd(4'h5, 8'h00);
    pulse(0, 3);
    pulse(1, 5);
    rd(4'h5, 8'h03);
    rd(4'h6, 8'h05);
    wr(4'h0, 8'h22);
    pulse(0, 2);
    pulse(1, 2);
    rd(4'h5, 8'h03);
    rd(4'h6, 8'h05);
    // Direct output flip-flop control
    wr(4'h3, 8'h08);
    @(negedge clk);
    chk({15'h0, wave_out_one}, 16'h1);
    wr(4'h3, 8'h0C);
    @(negedge clk);
    chk({15'h0, wave_out_one}, 16'h1);
    rd(4'h3, 8'h00);
    wr(4'h3, 8'h80);
    @(negedge clk);
    chk({15'h0, wave_out_two}, 16'h1);
    wr(4'h3, 8'h04);
    // Every internal rate with compare 0 in both oscillation modes
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h03);
    wr(4'h9, 8'h01);
    for (int m = 0; m < 2; m++) begin
      for (int c = 6; c < 16; c++) begin
        wr(4'h4, m[7:0]);
        wr(4'h0, c[7:0]);
        meas(0, 1 << ((c == 15 ? 11 : c - 5) + 1 - m));
      end
    end
    wr(4'h0, 8'h60);
    wr(4'h2, 8'h04);
    wr(4'h3, 8'h30);
    wr(4'h9, 8'h02);
    meas(1, 10);
    wr(4'h0, 8'h06);
    wr(4'h1, 8'hFF);
    wr(4'h3, 8'h03);
    wr(4'h9, 8'h01);
    meas(0, 512);
    // Interrupt raise, mask and clear
    wr(4'h8, 8'h01);
    repeat (3) @(negedge clk);
    chk({15'h0, irq}, 16'h1);
    rd(4'h7, 8'h03);
    wr(4'h8, 8'h00);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    wr(4'h9, 8'h00);
    wr(4'h7, 8'h03);
    rd(4'h7, 8'h00);
    wr(4'h8, 8'h03);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
